// ### pkg/seec_pkg.sv
// constants and types of the serial EEPROM command core
package seec_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 9;
  localparam int          MEM_DEPTH     = 512;
  localparam int          PAGE_W        = 4;
  localparam int          PAGE_BYTES    = 16;
  localparam int          BASE_W        = ADDR_W - PAGE_W;
  localparam int          BUF_DEPTH     = 2;
  localparam int          PTR_W         = $clog2(BUF_DEPTH);
  localparam int          CLK_MHZ       = 25;
  localparam int          WRITE_TIME_US = 5000;
  localparam int          WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
  // synchroniser reset value: sck, chip select, mosi, write protect
  localparam logic [3:0]  SYNC_RST      = 4'h5;
  // command byte: top nibble zero, opcode in the low three bits
  localparam logic [3:0]  CMD_TOP       = 4'h0;
  localparam int          CMD_ADDR_BIT  = 3;
  localparam logic [2:0]  OP_STATUS_WR  = 3'h1;
  localparam logic [2:0]  OP_ARRAY_WR   = 3'h2;
  localparam logic [2:0]  OP_ARRAY_RD   = 3'h3;
  localparam logic [2:0]  OP_LATCH_CLR  = 3'h4;
  localparam logic [2:0]  OP_STATUS_RD  = 3'h5;
  localparam logic [2:0]  OP_LATCH_SET  = 3'h6;
  // status byte layout
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_LATCH_BIT  = 1;
  localparam int          ST_PROT_LO    = 2;
  localparam int          ST_PROT_HI    = 3;
  localparam logic [3:0]  ST_UPPER      = 4'h0;
  // protect codes and delivery values
  localparam logic [1:0]  PROT_QUARTER  = 2'h1;
  localparam logic [1:0]  PROT_HALF     = 2'h2;
  localparam logic [1:0]  PROT_RST      = 2'h0;
  localparam logic [7:0]  FILL_BYTE     = 8'hFF;

  typedef enum logic [2:0] {
    SEEC_IDLE, SEEC_CMD, SEEC_ADDR, SEEC_READ, SEEC_WRITE,
    SEEC_STWR, SEEC_STRD, SEEC_DONE
  } seec_state_t;
  // ignore state shares the idle encoding; the eight states use every code, so the default branch of the state case is unreachable
  localparam seec_state_t SEEC_IGNORE = SEEC_IDLE;
endpackage : seec_pkg

// ### pkg/seec_stream_if.sv
// byte stream with valid and ready between core and buffer
`timescale 1ns/1ns
`default_nettype none
interface seec_stream_if;
  logic                      valid;
  logic                      ready;
  logic [seec_pkg::DATA_W-1:0] data;
  modport rx (input valid, input data, output ready);
  modport tx (output valid, output data, input ready);
endinterface : seec_stream_if
`default_nettype wire

// ### verif/seec_spi_master.sv
// SPI bus master model that drives the core's serial pins
`timescale 1ns/1ns
`default_nettype none
module seec_spi_master (
  input  wire logic clk,
  input  wire logic miso,
  input  wire logic misoOeN,
  output var logic  sck,
  output var logic  csN,
  output var logic  mosi
);
  logic misoAlt = 1'b0;
  logic drove;
  wire  misoLine = misoOeN ? misoAlt : miso;
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  // a released data line shows a changing pattern
  always @(posedge clk) begin
    misoAlt <= ~misoAlt;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  // one frame, bytes msb first; stray adds a clock rise after the last byte
  task automatic xfer(input logic [7:0] txQ[$], input bit stray, output logic [7:0] rxQ[$]);
    logic [7:0] rx;
    rxQ = {};
    drove = 1'b0;
    tick(1);
    csN = 1'b0;
    tick(4);
    foreach (txQ[k]) begin
      for (int i = 7; i >= 0; i--) begin
        mosi = txQ[k][i];
        tick(4);
        sck = 1'b1;
        tick(4);
        rx[i] = misoLine;
        drove = drove | ~misoOeN;
        sck = 1'b0;
      end
      rxQ.push_back(rx);
    end
    if (stray) begin
      tick(4);
      sck = 1'b1;
      tick(4);
      sck = 1'b0;
    end
    tick(2);
    csN = 1'b1;
    tick(8);
  endtask : xfer
endmodule : seec_spi_master
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the serial EEPROM command core
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import seec_pkg::*;
  localparam int WCyc = 400;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wpN = 1'b1;
  wire        sck, csN, mosi, miso, misoOeN, busy, writeLatch;
  wire  [1:0] protectSel;
  int         fail_count = 0;
  int         compares = 0;
  logic [1:0] protNow = 2'h0;
  logic [7:0] rxQ[$];
  always #20 clk = ~clk;
  seec_core #(.WriteCycles(WCyc)) i_seec_core (.clk(clk), .rst_n(rst_n), .sck(sck),
    .csN(csN), .mosi(mosi), .wpN(wpN), .miso(miso), .misoOeN(misoOeN), .busy(busy),
    .writeLatch(writeLatch), .protectSel(protectSel));
  seec_spi_master i_seec_spi_master (.clk(clk), .miso(miso), .misoOeN(misoOeN),
    .sck(sck), .csN(csN), .mosi(mosi));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : checkByte
  task automatic checkBit(input logic got, input logic exp, input string msg);
    checkByte({7'h00, got}, {7'h00, exp}, msg);
  endtask : checkBit
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic run(input logic [7:0] q[$], input bit stray = 1'b0);
    i_seec_spi_master.xfer(q, stray, rxQ);
  endtask : run
  task automatic wrByte(input logic [8:0] a, input logic [7:0] d, input bit stray = 1'b0);
    logic [7:0] c;
    c = {4'h0, a[8], 3'h2};
    run({c, a[7:0], d}, stray);
  endtask : wrByte
  task automatic rdBytes(input logic [8:0] a, input int n);
    logic [7:0] q[$];
    logic [7:0] c;
    c = {4'h0, a[8], 3'h3};
    q = {c, a[7:0]};
    repeat (n) q.push_back(8'h00);
    run(q);
  endtask : rdBytes
  task automatic waitIdle();
    int n;
    n = 0;
    while (busy !== 1'b0) begin
      tick(1);
      n++;
      if (n > 600) begin
        fail_count++;
        $display("wrong value at %0t: busy never cleared", $time);
        report_and_stop();
      end
    end
  endtask : waitIdle
  task automatic setProt(input logic [1:0] code);
    logic [7:0] v;
    v = {4'h0, code, 2'h0};
    run({8'h06});
    run({8'h01, v});
    checkByte({6'h00, protectSel}, {6'h00, protNow}, "protect during cycle");
    waitIdle();
    checkByte({6'h00, protectSel}, {6'h00, code}, "protect after cycle");
    checkBit(writeLatch, 1'b0, "latch after status cycle");
    run({8'h05, 8'h00});
    checkByte(rxQ[1], v, "status byte");
    protNow = code;
  endtask : setProt
  ////////////////////////////////////////////////////////////////////////////////
  task automatic resetState();
    checkBit(busy, 1'b0, "busy after reset");
    checkBit(writeLatch, 1'b0, "latch after reset");
    checkByte({6'h00, protectSel}, 8'h00, "protect at start");
    rdBytes(9'h000, 1);
    checkByte(rxQ[2], 8'hFF, "delivered byte");
  endtask : resetState
  task automatic latchCmds();
    run({8'h01, 8'h0C});
    checkBit(busy, 1'b0, "status write without latch");
    checkByte({6'h00, protectSel}, 8'h00, "refused status write");
    run({8'h06});
    checkBit(writeLatch, 1'b1, "latch set");
    run({8'h04});
    checkBit(writeLatch, 1'b0, "latch clear");
    run({8'h86});
    checkBit(writeLatch, 1'b0, "unknown code");
    run({8'h06});
    run({8'h01, 8'h0C}, 1'b1);
    checkBit(busy, 1'b0, "status write late select");
    checkBit(writeLatch, 1'b1, "latch kept");
  endtask : latchCmds
  task automatic pageWrite();
    logic [7:0] exp[4];
    exp = '{8'hA1, 8'hB2, 8'h5A, 8'hFF};
    run({8'h0A, 8'hFE, 8'hA1, 8'hB2, 8'hC3});
    checkBit(busy, 1'b1, "write cycle started");
    run({8'h05, 8'h00});
    checkByte(rxQ[1], 8'h03, "status while busy");
    rdBytes(9'h1FE, 1);
    checkBit(i_seec_spi_master.drove, 1'b0, "read while busy");
    waitIdle();
    checkBit(writeLatch, 1'b0, "latch after write");
    run({8'h06});
    wrByte(9'h000, 8'h5A);
    waitIdle();
    rdBytes(9'h1FE, 4);
    foreach (exp[i]) checkByte(rxQ[2+i], exp[i], "sequential read");
    rdBytes(9'h1F0, 1);
    checkByte(rxQ[2], 8'hC3, "page wrap");
    checkBit(misoOeN, 1'b1, "released after select");
  endtask : pageWrite
  task automatic protect();
    logic [1:0] code[3];
    logic [8:0] edgeA[3];
    logic [7:0] edgeV[3];
    code = '{2'h1, 2'h2, 2'h3};
    edgeA = '{9'h180, 9'h100, 9'h000};
    edgeV = '{8'hFF, 8'hFF, 8'h5A};
    foreach (code[k]) begin
      setProt(code[k]);
      run({8'h06});
      wrByte(edgeA[k], 8'h11);
      checkBit(busy, 1'b0, "protected write");
      checkBit(writeLatch, 1'b1, "latch after refusal");
      if (k < 2) begin
        wrByte(edgeA[k] - 9'h001, 8'h22);
        checkBit(busy, 1'b1, "write below area");
        waitIdle();
      end
      rdBytes(edgeA[k] - 9'h001, 2);
      checkByte(rxQ[3], edgeV[k], "protected byte");
    end
    setProt(2'h0);
  endtask : protect
  task automatic wpPin();
    run({8'h06});
    checkBit(writeLatch, 1'b1, "latch before protect pin");
    wpN = 1'b0;
    tick(4);
    checkBit(writeLatch, 1'b0, "latch with protect pin");
    run({8'h06});
    run({8'h01, 8'h0C});
    checkBit(busy, 1'b0, "status write with protect pin");
    wpN = 1'b1;
    run({8'h06});
    fork
      wrByte(9'h010, 8'h33);
      begin
        tick(100);
        wpN = 1'b0;
        tick(8);
        wpN = 1'b1;
      end
    join
    checkBit(busy, 1'b0, "protect pin in frame");
    run({8'h06});
    wrByte(9'h010, 8'h44, 1'b1);
    checkBit(busy, 1'b0, "write late select");
    rdBytes(9'h010, 1);
    checkByte(rxQ[2], 8'hFF, "refused writes");
  endtask : wpPin
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    #2;
    rst_n = 1'b1;
    tick(4);
    resetState();
    latchCmds();
    pageWrite();
    protect();
    wpPin();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire

// ### verilog/seec_core.sv
// serial EEPROM command core behind the SPI slave pins
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - status write needs latch set beforehand
// - status write executes only on exact byte end
// - valid status write starts timed cycle
// - busy flag high during cycle, low after
// - latch cleared when status cycle ends
// - new protect bits apply after cycle
// - status write keeps other bits, upper read zero
// - status write refused: latch, busy, protect pin
// - read is command plus address, top bit in command
// - read shifts data, pointer advances each byte
// - read address wraps from top to zero
// - raising select ends a read anywhere
// - read ignored while write cycle runs
// - address bits above width are ignored
// - array write starts cycle at byte boundary
// - extra bytes wrap inside the page
// - array write refused on latch, busy, protection
// - timed write erases then programs bytes
// - reset leaves deselected idle, flags cleared
// - protect bits survive reset
// - delivered array all ones, protect cleared
// - unknown command byte deselects the device
// - latch cleared by disable, completion, protect pin
// - protect code selects quarter, half or all
module seec_core #(
  parameter int unsigned WriteCycles = seec_pkg::WRITE_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 sck,
  input  wire logic                 csN,
  input  wire logic                 mosi,
  input  wire logic                 wpN,
  output logic                      miso,
  output logic                      misoOeN,
  output logic                      busy,
  output logic                      writeLatch,
  output logic [1:0]                protectSel
);
  import seec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edges
  logic [3:0]         meta_q;
  logic [3:0]         sync_q;
  logic               sckPrev_q;
  logic               csPrev_q;
  wire                sckS = sync_q[3];
  wire                csS  = sync_q[2];
  wire                mosiS = sync_q[1];
  wire                wpS  = sync_q[0];
  wire                sckRise = sckS & ~sckPrev_q;
  wire                sckFall = ~sckS & sckPrev_q;
  wire                csRise = csS & ~csPrev_q;
  wire                csFall = ~csS & csPrev_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q    <= SYNC_RST;
      sync_q    <= SYNC_RST;
      sckPrev_q <= 1'b0;
      csPrev_q  <= 1'b1;
    end else begin
      meta_q    <= {sck, csN, mosi, wpN};
      sync_q    <= meta_q;
      sckPrev_q <= sckS;
      csPrev_q  <= csS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame state
  seec_state_t        state_q;
  seec_state_t        state_d;
  logic               ignore_q;
  logic [2:0]         bitCnt_q;
  logic [6:0]         rxSh_q;
  logic [2:0]         op_q;
  logic               addrHi_q;
  logic               wpSeen_q;
  logic [PAGE_W-1:0]  col_q;
  logic [BASE_W-1:0]  pageBase_q;
  logic [PAGE_BYTES-1:0] pageMask_q;
  logic [DATA_W-1:0]  pageMem [PAGE_BYTES];
  logic [1:0]         protNew_q;
  logic [ADDR_W-1:0]  readAddr_q;
  logic [DATA_W-1:0]  txSh_q;
  logic               busy_q;
  logic               arrayCycle_q;
  logic [31:0]        timer_q;
  logic [PAGE_W:0]    copy_q;
  logic               latch_q;
  logic [1:0]         prot_q = PROT_RST;
  logic [DATA_W-1:0]  mem [MEM_DEPTH] = '{default: FILL_BYTE};

  wire [DATA_W-1:0]   rxByte   = {rxSh_q, mosiS};
  wire                byteDone = sckRise & (bitCnt_q == 3'h7) & ~ignore_q;
  wire [2:0]          cmdOp    = rxByte[2:0];
  wire                cmdOk    = rxByte[7:4] == CMD_TOP;
  wire                writeOk  = latch_q & ~busy_q;
  wire [ADDR_W-1:0]   fullAddr = {addrHi_q, rxByte};
  wire                active   = state_q != SEEC_IDLE;
  wire                endCycle = busy_q & (timer_q == '0);
  wire [DATA_W-1:0]   statusByte = {ST_UPPER, prot_q, latch_q, busy_q};
  // protected area of the addressed page
  wire                protHit = (&prot_q)
                              | ((prot_q == PROT_HALF) & pageBase_q[BASE_W-1])
                              | ((prot_q == PROT_QUARTER) & (&pageBase_q[BASE_W-1:BASE_W-2]));
  wire                pinsOk = ~wpSeen_q & wpS;
  wire                commitStatus = csRise & (state_q == SEEC_DONE) & ~ignore_q
                                   & (op_q == OP_STATUS_WR) & pinsOk & writeOk;
  wire                commitArray = csRise & (state_q == SEEC_WRITE) & ~ignore_q
                                  & (bitCnt_q == 3'h0) & (pageMask_q != '0)
                                  & pinsOk & writeOk & ~protHit;
  wire                latchSet = csRise & (state_q == SEEC_DONE) & ~ignore_q
                               & (op_q == OP_LATCH_SET);
  wire                latchClr = csRise & (state_q == SEEC_DONE) & ~ignore_q
                               & (op_q == OP_LATCH_CLR);
  wire                startCycle = commitStatus | commitArray;

  // next state; an ignored frame parks until select rises
  always_comb begin
    state_d = state_q;
    case (state_q)
      SEEC_IDLE: begin
        if (csFall) state_d = SEEC_CMD;
      end
      SEEC_CMD: begin
        if (byteDone) begin
          if (!cmdOk) state_d = SEEC_IDLE;
          else begin
            case (cmdOp)
              OP_LATCH_SET, OP_LATCH_CLR: state_d = SEEC_DONE;
              OP_STATUS_RD: state_d = SEEC_STRD;
              OP_STATUS_WR: state_d = writeOk ? SEEC_STWR : SEEC_IDLE;
              OP_ARRAY_RD: state_d = busy_q ? SEEC_IDLE : SEEC_ADDR;
              OP_ARRAY_WR: state_d = writeOk ? SEEC_ADDR : SEEC_IDLE;
              default: state_d = SEEC_IDLE;
            endcase
          end
        end
      end
      SEEC_ADDR: begin
        if (byteDone) state_d = (op_q == OP_ARRAY_RD) ? SEEC_READ : SEEC_WRITE;
      end
      SEEC_STWR: begin
        if (byteDone) state_d = SEEC_DONE;
      end
      SEEC_DONE: begin
        if (sckRise) state_d = SEEC_IDLE;
      end
      SEEC_READ, SEEC_WRITE, SEEC_STRD: state_d = state_q;
      default: state_d = SEEC_IDLE;
    endcase
    if (csS) state_d = SEEC_IDLE;
  end

  // ignore flag marks an idle that is still selected
  wire ignore_d = ~csS & ~csFall & (ignore_q | (active & (state_d == SEEC_IDLE)));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q  <= SEEC_IDLE;
      ignore_q <= 1'b0;
      bitCnt_q <= 3'h0;
      wpSeen_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      ignore_q <= ignore_d;
      bitCnt_q <= csFall ? 3'h0 : bitCnt_q + 3'(sckRise);
      wpSeen_q <= csFall ? ~wpS : (wpSeen_q | ~wpS);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift in, command and page capture
  always_ff @(posedge clk) begin
    if (sckRise) rxSh_q <= rxByte[6:0];
    if (byteDone && state_q == SEEC_CMD) begin
      op_q     <= cmdOp;
      addrHi_q <= rxByte[CMD_ADDR_BIT];
    end
    if (byteDone && state_q == SEEC_ADDR) begin
      pageBase_q <= fullAddr[ADDR_W-1:PAGE_W];
      col_q      <= fullAddr[PAGE_W-1:0];
    end
    if (byteDone && state_q == SEEC_STWR) protNew_q <= rxByte[ST_PROT_HI:ST_PROT_LO];
    if (byteDone && state_q == SEEC_WRITE) begin
      pageMem[col_q] <= rxByte;
      col_q          <= col_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    // cleared at address capture, so a copy still running keeps its mask
    if (!rst_n || (byteDone && state_q == SEEC_ADDR)) pageMask_q <= '0;
    else if (byteDone && state_q == SEEC_WRITE) pageMask_q[col_q] <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read stream through the two-entry buffer
  seec_stream_if rdIn ();
  seec_stream_if rdOut ();

  assign rdIn.valid  = state_q == SEEC_READ;
  assign rdIn.data   = mem[readAddr_q];
  assign rdOut.ready = sckFall & (bitCnt_q == 3'h0) & (state_q == SEEC_READ);

  seec_stream_buf u_buf (
    .clk   (clk),
    .rst_n (rst_n),
    .flush (state_q != SEEC_READ),
    .inS   (rdIn),
    .outS  (rdOut)
  );

  always_ff @(posedge clk) begin
    if (byteDone && state_q == SEEC_ADDR) readAddr_q <= fullAddr;
    else if (rdIn.valid && rdIn.ready) readAddr_q <= readAddr_q + 1'b1;
  end

  wire [DATA_W-1:0] loadByte = (state_q == SEEC_STRD) ? statusByte
                             : (rdOut.valid ? rdOut.data : '0);

  always_ff @(posedge clk) begin
    if (!rst_n) txSh_q <= '0;
    else if (sckFall && bitCnt_q == 3'h0) txSh_q <= loadByte;
    else if (sckFall) txSh_q <= {txSh_q[DATA_W-2:0], 1'b0};
  end

  assign miso    = txSh_q[DATA_W-1];
  assign misoOeN = ~((state_q == SEEC_READ) | (state_q == SEEC_STRD));

  ////////////////////////////////////////////////////////////////////////////
  // timed write cycle, latch and protect bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q       <= 1'b0;
      timer_q      <= '0;
      copy_q       <= '0;
      arrayCycle_q <= 1'b0;
    end else if (startCycle) begin
      busy_q       <= 1'b1;
      timer_q      <= 32'(WriteCycles - 1);
      copy_q       <= '0;
      arrayCycle_q <= commitArray;
    end else if (busy_q) begin
      busy_q  <= ~endCycle;
      timer_q <= timer_q - 1'b1;
      copy_q  <= copy_q + (PAGE_W+1)'(copy_q != (PAGE_W+1)'(PAGE_BYTES));
    end
  end

  // erase and program collapse to one store of the new byte
  wire copyHit = busy_q & arrayCycle_q & (copy_q != (PAGE_W+1)'(PAGE_BYTES))
               & pageMask_q[copy_q[PAGE_W-1:0]];

  always_ff @(posedge clk) begin
    if (copyHit) mem[{pageBase_q, copy_q[PAGE_W-1:0]}] <= pageMem[copy_q[PAGE_W-1:0]];
  end

  // protect bits are non-volatile: no reset
  always_ff @(posedge clk) begin
    if (endCycle && !arrayCycle_q) prot_q <= protNew_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !wpS) latch_q <= 1'b0;
    else if (latchSet) latch_q <= 1'b1;
    else if (endCycle || latchClr) latch_q <= 1'b0;
  end

  assign busy       = busy_q;
  assign writeLatch = latch_q;
  assign protectSel = prot_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  busy_end_a: assert property (endCycle |=> !busy_q)
    else $error("busy flag did not clear at cycle end");
  latch_end_a: assert property ($fell(busy_q) |-> !latch_q || $past(latchSet))
    else $error("latch still set after write cycle");
  prot_hold_a: assert property (!$stable(prot_q) |-> $fell(busy_q))
    else $error("protect bits changed outside cycle end");
  status_start_a: assert property (commitStatus |=> busy_q ##1 busy_q)
    else $error("status write did not start cycle");
  read_busy_a: assert property (byteDone && state_q == SEEC_CMD && cmdOk
    && cmdOp == OP_ARRAY_RD && busy_q |=> state_q == SEEC_IDLE)
    else $error("read accepted while busy");
  pin_latch_a: assert property (!wpS |=> !latch_q)
    else $error("latch set while protect pin low");
  no_start_a: assert property ($rose(busy_q) |-> $past(startCycle))
    else $error("cycle started without valid commit");
  read_wrap_a: assert property (rdIn.valid && rdIn.ready && (&readAddr_q)
    && !(byteDone && state_q == SEEC_ADDR) |=> readAddr_q == '0)
    else $error("read address did not wrap");
  bad_cmd_a: assert property (byteDone && state_q == SEEC_CMD && !cmdOk
    |=> state_q == SEEC_IDLE)
    else $error("unknown command not ignored");
  prot_write_a: assert property (commitArray |-> latch_q && !busy_q && !wpSeen_q
    && (prot_q == PROT_RST || (prot_q == PROT_HALF && !pageBase_q[BASE_W-1])
    || (prot_q == PROT_QUARTER && !(pageBase_q[BASE_W-1] && pageBase_q[BASE_W-2]))))
    else $error("protected page write started");

  status_cv: cover property (commitStatus);
  array_cv: cover property (commitArray ##[1:40] copyHit);
  read_cv: cover property (rdOut.ready && rdOut.valid);
  stat_rd_cv: cover property (state_q == SEEC_STRD && busy_q && sckFall);
endmodule : seec_core
`default_nettype wire

// ### verilog/seec_stream_buf.sv
// two-entry buffer for the read data stream
`timescale 1ns/1ns
`default_nettype none
module seec_stream_buf (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      flush,
  seec_stream_if.rx      inS,
  seec_stream_if.tx      outS
);
  import seec_pkg::*;

  logic [DATA_W-1:0] slot_q [BUF_DEPTH];
  logic [PTR_W-1:0]  wrPtr_q;
  logic [PTR_W-1:0]  rdPtr_q;
  logic [PTR_W:0]    cnt_q;
  wire               push;
  wire               pop;

  assign inS.ready  = cnt_q != (PTR_W+1)'(BUF_DEPTH);
  assign outS.valid = cnt_q != '0;
  assign outS.data  = slot_q[rdPtr_q];
  assign push       = inS.valid & inS.ready;
  assign pop        = outS.valid & outS.ready;

  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q   <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + PTR_W'(push);
      rdPtr_q <= rdPtr_q + PTR_W'(pop);
      cnt_q   <= cnt_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      slot_q[wrPtr_q] <= inS.data;
    end
  end
endmodule : seec_stream_buf
`default_nettype wire
